// ---- verilog/dcc_pkg.sv ----
// Purpose: shared constants for the decoder clock control block
// Assumes: one 100 MHz mclk stands in for the multiplied master clock
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package dcc_pkg;
  // master clock figures, for reference only; no logic or check uses them
  localparam real XTAL_MHZ = 8.4672;
  localparam int XTAL_MULT = 8;
  localparam real MASTER_MHZ = 67.7376;
  localparam real BUS_CLK_MHZ = 100.0;
  // register byte offsets
  localparam logic [7:0] SYSTEM_CLOCK_CONFIG = 8'h00;
  localparam logic [7:0] BIT_CLOCK_CONFIG_A = 8'h04;
  localparam logic [7:0] SPDIF_CLOCK_CONFIG = 8'h08;
  localparam logic [7:0] AUX_CLOCK_CONFIG = 8'h0c;
  localparam logic [7:0] SERIAL_AUDIO_CONFIG = 8'h10;
  localparam logic [7:0] ANALOG_MULTIPLIER_CONTROL = 8'h14;
  localparam logic [7:0] CORE_BUS_CLOCK_CONFIG = 8'h18;
  localparam logic [7:0] CLOCK_STATUS = 8'h1c;
  // field positions
  localparam int SYS_DIV_LSB = 0;
  localparam int SYS_DIV_W = 3;
  localparam int SLEEP_BIT = 4;
  localparam int BITDIV_W = 8;
  localparam int GATE_BIT = 8;
  localparam int SPDIFDIV_W = 8;
  localparam int AUXDIV_W = 8;
  localparam int DACDIV_LSB = 8;
  localparam int RECEIVE_BIT = 0;
  localparam int SLAVE_BIT = 1;
  localparam int XTAL16_BIT = 0;
  localparam int COREDIV_W = 4;
  localparam int DIV_W = 8;
  localparam int SAMPLE_W = 6;
  localparam int DUMP_W = 11;
  // reset values and the system divider limit
  localparam logic [2:0] SYS_DIV_RESET = 3'h0;
  localparam logic [2:0] SYS_DIV_MAX = 3'h4;
  localparam logic [7:0] DIV_RESET = 8'h10;
  localparam logic [3:0] COREDIV_RESET = 4'h1;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- verilog/dcc_divider.sv ----
// Purpose: programmable clock divider with level output and rise pulse
// Assumes: half is the half period in mclk cycles, zero taken as one
// Notes: a new half period is taken only at the start of a full period or while stopped
`timescale 1ns/1ps
module dcc_divider (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic run,
  input wire logic [dcc_pkg::DIV_W-1:0] half,
  output logic clkOut,
  output logic rise
);
  logic [dcc_pkg::DIV_W-1:0] count;
  logic [dcc_pkg::DIV_W-1:0] activeHalf;
  logic expire;

  assign expire = (count + 8'h01 >= activeHalf);
  assign rise = ce & run & expire & ~clkOut;

  // setting latched on the rising edge or while stopped, so no short pulses appear
  always_ff @(posedge mclk) begin
    if (reset) begin
      activeHalf <= 8'h01;
    end else if (ce && (rise || !run)) begin
      activeHalf <= (half == 8'h00) ? 8'h01 : half;
    end
  end

  // half-period counter; stopped divider parks low
  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= 8'h00;
      clkOut <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        count <= 8'h00;
        clkOut <= 1'b0;
      end else if (expire) begin
        count <= 8'h00;
        clkOut <= ~clkOut;
      end else begin
        count <= count + 8'h01;
      end
    end
  end
endmodule

// ---- verilog/dcc_int_dump.sv ----
// Purpose: integrate-and-dump from the sample rate to the system rate
// Assumes: one ADC sample per enabled mclk cycle
// Notes: sum is left aligned so every factor gives the same scale
`timescale 1ns/1ps
module dcc_int_dump (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [dcc_pkg::SAMPLE_W-1:0] sample,
  input wire logic [2:0] logFactor,
  output logic [dcc_pkg::DUMP_W-1:0] dumpSample,
  output logic dumpValid
);
  logic [dcc_pkg::DUMP_W-1:0] acc;
  logic [4:0] count;
  logic [2:0] activeLog;
  logic [4:0] last;
  logic [dcc_pkg::DUMP_W-1:0] sum;

  assign last = 5'((6'h01 << activeLog) - 6'h01);
  assign sum = acc + {5'h00, sample};

  // averages 2..32 samples, one result per system clock period
  always_ff @(posedge mclk) begin
    if (reset) begin
      acc <= '0;
      count <= 5'h00;
      activeLog <= 3'h1;
      dumpSample <= '0;
      dumpValid <= 1'b0;
    end else if (ce) begin
      dumpValid <= 1'b0;
      if (count == last) begin
        dumpSample <= DUMP_SHIFT(sum, activeLog);
        dumpValid <= 1'b1;
        acc <= '0;
        count <= 5'h00;
        activeLog <= logFactor; // factor changes only between dumps
      end else begin
        acc <= sum;
        count <= count + 5'h01;
      end
    end
  end

  function automatic logic [dcc_pkg::DUMP_W-1:0] DUMP_SHIFT(
    input logic [dcc_pkg::DUMP_W-1:0] s, input logic [2:0] l);
    DUMP_SHIFT = s << (3'h5 - l);
  endfunction
endmodule

// ---- verilog/dcc_clock_control.sv ----
// Summary of operation
// - separate dividers for the decoder domain and the system bus core clock
// - generate system, audio bit, SPDIF and ADC sample clock domains
// - master clock is crystal times eight, fixed at 67.7376 MHz
// - 16 MHz crystal select halves the crystal before multiplication
// - system clock is master over two, 50 % duty, then programmable divide
// - sleep control in system config stops most decoder clocks
// - serial audio back-end uses bit clock, which is also driven out
// - bit clock divider and gating enable share one config register
// - SPDIF back-end has own clock; its output enabled only in slave mode
// - ADC sample clock fixed at master rate, capturing RF ADC samples
// - receive select clocks serial audio back-end from external bit clock
// - monitor clock for debug lines, rate set in aux clock register
// - external converter clock, rate set in aux clock register
// - ADC samples move into system domain through integrate-and-dump
// - integrate-and-dump averages 2 to 32 samples per system clock
//
// Purpose: decoder clock control with AXI4-Lite configuration registers
// Assumes: mclk stands for the master clock; derived clocks are levels
// Notes: derived clocks are divided outputs on mclk; only the system clock also has a rise enable, systemTick
`timescale 1ns/1ps
module dcc_clock_control (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock pins and consumers
  input wire logic [dcc_pkg::SAMPLE_W-1:0] adcSample,
  input wire logic bitClockIn,
  input wire logic bitClockRequest,
  output logic crystalHalve,
  output logic adcSampleTick,
  output logic systemClock,
  output logic systemTick,
  output logic coreBusClock,
  output logic bitClockOut,
  output logic bitClockOe,
  output logic backendBitClock,
  output logic spdifClock,
  output logic spdifEnable,
  output logic debugMonitorClock,
  output logic externalDacClock,
  output logic [dcc_pkg::DUMP_W-1:0] dumpSample,
  output logic dumpValid
);
  // configuration registers
  logic [2:0] systemDividerField;
  logic sleep;
  logic [7:0] bitDivider;
  logic bitGate;
  logic [7:0] spdifDivider;
  logic [7:0] monitorDivider;
  logic [7:0] dacDivider;
  logic receiveBitClock;
  logic slaveMode;
  logic crystal16mSelect;
  logic [3:0] coreDivider;

  // bus state
  logic [7:0] awAddr;
  logic awHeld;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wHeld;
  logic writeGo;
  logic wrHit;
  logic rdHit;
  logic [31:0] rdValue;

  // divider internals
  logic [7:0] sysHalf;
  logic sysRun;
  logic bitRun;
  logic internalBitClock;
  logic [3:0] coreCount;
  logic [3:0] activeCoreDiv;

  // address decode, shared by the read and write paths
  function automatic logic HIT(input logic [7:0] a);
    HIT = (a == dcc_pkg::SYSTEM_CLOCK_CONFIG) || (a == dcc_pkg::BIT_CLOCK_CONFIG_A) ||
      (a == dcc_pkg::SPDIF_CLOCK_CONFIG) || (a == dcc_pkg::AUX_CLOCK_CONFIG) ||
      (a == dcc_pkg::SERIAL_AUDIO_CONFIG) || (a == dcc_pkg::ANALOG_MULTIPLIER_CONTROL) ||
      (a == dcc_pkg::CORE_BUS_CLOCK_CONFIG) || (a == dcc_pkg::CLOCK_STATUS);
  endfunction

  // byte-lane merge for a write
  function automatic logic [31:0] MERGE(input logic [31:0] old, input logic [31:0] d,
    input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    MERGE = m;
  endfunction

  // write address and data are held independently; either may come first
  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
  assign writeGo = awHeld & wHeld & ~s_axi_bvalid;
  assign wrHit = HIT(awAddr) && (awAddr != dcc_pkg::CLOCK_STATUS);

  always_ff @(posedge mclk) begin
    if (reset) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (writeGo) begin
        awHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wHeld <= 1'b0;
      wData <= 32'h0;
      wStrb <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (writeGo) begin
        wHeld <= 1'b0;
      end
    end
  end

  // write response; unmapped or status address answers SLVERR
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dcc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (writeGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes
  always_ff @(posedge mclk) begin
    logic [31:0] v;
    v = 32'h0;
    if (reset) begin
      systemDividerField <= dcc_pkg::SYS_DIV_RESET;
      sleep <= 1'b0;
      bitDivider <= dcc_pkg::DIV_RESET;
      bitGate <= 1'b0;
      spdifDivider <= dcc_pkg::DIV_RESET;
      monitorDivider <= dcc_pkg::DIV_RESET;
      dacDivider <= dcc_pkg::DIV_RESET;
      receiveBitClock <= 1'b0;
      slaveMode <= 1'b0;
      crystal16mSelect <= 1'b0;
      coreDivider <= dcc_pkg::COREDIV_RESET;
    end else if (ce && writeGo) begin
      unique case (awAddr)
        dcc_pkg::SYSTEM_CLOCK_CONFIG: begin
          v = MERGE({27'h0, sleep, 1'b0, systemDividerField}, wData, wStrb);
          // codes above the largest factor are clamped to it
          systemDividerField <= (v[2:0] > dcc_pkg::SYS_DIV_MAX) ? dcc_pkg::SYS_DIV_MAX : v[2:0];
          sleep <= v[dcc_pkg::SLEEP_BIT];
        end
        dcc_pkg::BIT_CLOCK_CONFIG_A: begin
          v = MERGE({23'h0, bitGate, bitDivider}, wData, wStrb);
          bitDivider <= v[7:0];
          bitGate <= v[dcc_pkg::GATE_BIT];
        end
        dcc_pkg::SPDIF_CLOCK_CONFIG: begin
          v = MERGE({24'h0, spdifDivider}, wData, wStrb);
          spdifDivider <= v[7:0];
        end
        dcc_pkg::AUX_CLOCK_CONFIG: begin
          v = MERGE({16'h0, dacDivider, monitorDivider}, wData, wStrb);
          monitorDivider <= v[7:0];
          dacDivider <= v[dcc_pkg::DACDIV_LSB +: 8];
        end
        dcc_pkg::SERIAL_AUDIO_CONFIG: begin
          v = MERGE({30'h0, slaveMode, receiveBitClock}, wData, wStrb);
          receiveBitClock <= v[dcc_pkg::RECEIVE_BIT];
          slaveMode <= v[dcc_pkg::SLAVE_BIT];
        end
        dcc_pkg::ANALOG_MULTIPLIER_CONTROL: begin
          v = MERGE({31'h0, crystal16mSelect}, wData, wStrb);
          crystal16mSelect <= v[dcc_pkg::XTAL16_BIT];
        end
        dcc_pkg::CORE_BUS_CLOCK_CONFIG: begin
          v = MERGE({28'h0, coreDivider}, wData, wStrb);
          coreDivider <= (v[3:0] == 4'h0) ? dcc_pkg::COREDIV_RESET : v[3:0];
        end
        default: begin
          v = 32'h0; // unmapped: no register changes
        end
      endcase
    end
  end

  // read mux; status shows live clock levels and the last dumped sample
  always_comb begin
    rdHit = HIT(s_axi_araddr);
    rdValue = 32'h0;
    unique case (s_axi_araddr)
      dcc_pkg::SYSTEM_CLOCK_CONFIG: rdValue = {27'h0, sleep, 1'b0, systemDividerField};
      dcc_pkg::BIT_CLOCK_CONFIG_A: rdValue = {23'h0, bitGate, bitDivider};
      dcc_pkg::SPDIF_CLOCK_CONFIG: rdValue = {24'h0, spdifDivider};
      dcc_pkg::AUX_CLOCK_CONFIG: rdValue = {16'h0, dacDivider, monitorDivider};
      dcc_pkg::SERIAL_AUDIO_CONFIG: rdValue = {30'h0, slaveMode, receiveBitClock};
      dcc_pkg::ANALOG_MULTIPLIER_CONTROL: rdValue = {31'h0, crystal16mSelect};
      dcc_pkg::CORE_BUS_CLOCK_CONFIG: rdValue = {28'h0, coreDivider};
      dcc_pkg::CLOCK_STATUS: rdValue = {dumpSample, 13'h0, spdifEnable, backendBitClock,
        systemClock, sysRun, bitRun, coreBusClock, spdifClock, debugMonitorClock};
      default: rdValue = 32'h0;
    endcase
  end

  // read channel: address taken when no answer is pending
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= dcc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdValue;
        s_axi_rresp <= rdHit ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // crystal path control goes to the analog multiplier
  assign crystalHalve = crystal16mSelect;

  // ADC samples are taken every master cycle, never gated by sleep
  assign adcSampleTick = ce;

  // system clock half period is 2^field master cycles: master/2 at field 0
  assign sysHalf = 8'(8'h01 << systemDividerField);
  assign sysRun = ~sleep;

  dcc_divider u_sys (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .run(sysRun),
    .half(sysHalf),
    .clkOut(systemClock),
    .rise(systemTick)
  );

  // gated bit clock runs only while the back-end asks for bits
  assign bitRun = ~sleep & ~receiveBitClock & (~bitGate | bitClockRequest);

  dcc_divider u_bit (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .run(bitRun),
    .half(bitDivider),
    .clkOut(internalBitClock),
    .rise()
  );

  // driven out unless receiving; back-end follows whichever source is active
  assign bitClockOut = internalBitClock;
  assign bitClockOe = ~receiveBitClock;
  assign backendBitClock = receiveBitClock ? bitClockIn : internalBitClock;

  dcc_divider u_spdif (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .run(sysRun),
    .half(spdifDivider),
    .clkOut(spdifClock),
    .rise()
  );

  assign spdifEnable = slaveMode & ~sleep;

  dcc_divider u_mon (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .run(sysRun),
    .half(monitorDivider),
    .clkOut(debugMonitorClock),
    .rise()
  );

  dcc_divider u_dac (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .run(sysRun),
    .half(dacDivider),
    .clkOut(externalDacClock),
    .rise()
  );

  // core bus divider is independent of the decoder and keeps running in sleep
  always_ff @(posedge mclk) begin
    if (reset) begin
      coreCount <= 4'h0;
      coreBusClock <= 1'b0;
      activeCoreDiv <= dcc_pkg::COREDIV_RESET;
    end else if (ce) begin
      if (coreCount + 4'h1 >= activeCoreDiv) begin
        coreCount <= 4'h0;
        coreBusClock <= ~coreBusClock;
        if (coreBusClock) begin
          activeCoreDiv <= coreDivider;
        end
      end else begin
        coreCount <= coreCount + 4'h1;
      end
    end
  end

  // factor 2^(field+1) matches the system clock period in master cycles
  dcc_int_dump u_dump (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .sample(adcSample),
    .logFactor(systemDividerField + 3'h1),
    .dumpSample(dumpSample),
    .dumpValid(dumpValid)
  );
endmodule

// ---- bench/dcc_backend_model.sv ----
// Purpose: audio back-end stand-in on the far side of the clock block
// Assumes: bit clock demand and external clock frames set by the bench
// Notes: external clock stands still low outside frames
`timescale 1ns/1ps
module dcc_backend_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic demand,
  input wire logic extRun,
  output logic bitClockRequest,
  output logic bitClockIn
);
  logic [1:0] cnt;
  // request is a level; back-end asks for bit clock while it has data to move
  always_ff @(posedge mclk) begin
    bitClockRequest <= reset ? 1'b0 : demand;
  end
  // external bit clock, half period of three cycles, only within frames
  always_ff @(posedge mclk) begin
    if (reset || !extRun) begin
      cnt <= 2'h0;
      bitClockIn <= 1'b0;
    end else if (cnt == 2'h2) begin
      cnt <= 2'h0;
      bitClockIn <= ~bitClockIn;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

// ---- bench/dcc_clock_control_assertions.sv ----
// Purpose: port-level timing checks of the decoder clock control
// Assumes: sampled on mclk; frozen cycles (ce low) are judged only by the sample tick check
// Notes: bound to every dcc_clock_control instance
`timescale 1ns/1ps
module dcc_clock_control_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic adcSampleTick,
  input wire logic bitClockIn,
  input wire logic systemClock,
  input wire logic systemTick,
  input wire logic bitClockOut,
  input wire logic bitClockOe,
  input wire logic backendBitClock,
  input wire logic spdifClock,
  input wire logic dumpValid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset || !ce);
  // both halves of a write taken in one cycle
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_write_answer; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
  property p_read_answer; s_rd_taken |-> ##[1:2] s_axi_rvalid; endproperty
  property p_resp_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_rdata_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_adc_tick; disable iff (reset) adcSampleTick == ce; endproperty
  property p_receive_path; !bitClockOe |-> backendBitClock == bitClockIn; endproperty
  property p_transmit_path; bitClockOe |-> backendBitClock == bitClockOut; endproperty
  property p_sys_tick; systemTick |=> $rose(systemClock); endproperty
  property p_sys_rise; $rose(systemClock) |-> $past(systemTick); endproperty
  property p_reset_idle;
    disable iff (!ce) reset |=> !systemClock && !spdifClock && !bitClockOut && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_dump_pulse; dumpValid |=> !dumpValid; endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response late");
  a_read_answer: assert property (p_read_answer) else $error("read data late");
  a_resp_hold: assert property (p_resp_hold) else $error("write response dropped");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
  a_adc_tick: assert property (p_adc_tick) else $error("sample tick not at master rate");
  a_receive_path: assert property (p_receive_path) else $error("back-end not on external clock");
  a_transmit_path: assert property (p_transmit_path) else $error("back-end clock differs from pin");
  a_sys_tick: assert property (p_sys_tick) else $error("tick without system clock rise");
  a_sys_rise: assert property (p_sys_rise) else $error("system clock rise without tick");
  a_reset_idle: assert property (p_reset_idle) else $error("clocks or bus busy in reset");
  a_dump_pulse: assert property (p_dump_pulse) else $error("dump faster than two samples");
endmodule
bind dcc_clock_control dcc_clock_control_checker i_chk (.mclk(mclk), .reset(reset), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .adcSampleTick(adcSampleTick), .bitClockIn(bitClockIn), .systemClock(systemClock),
  .systemTick(systemTick), .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
  .backendBitClock(backendBitClock), .spdifClock(spdifClock), .dumpValid(dumpValid));

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the decoder clock control
// Assumes: ce held high except for one short freeze in the mode test; a constant ADC sample
// Notes: outputs sampled at rising edges, before that edge's updates land
`timescale 1ns/1ps
module tb;
  logic mclk, reset, ce, awValid, wValid, bReady, arValid, rReady, demand, extRun;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  logic awReady, wReady, bValid, arReady, rValid, bitClockIn, bitClockRequest, crystalHalve, adcSampleTick;
  logic systemClock, systemTick, coreBusClock, bitClockOut, bitClockOe, backendBitClock, spdifClock;
  logic spdifEnable, debugMonitorClock, externalDacClock, dumpValid;
  logic [5:0] adcSample;
  logic [10:0] dumpSample;
  int mismatches, n_checks;
  dcc_clock_control i_dut (.mclk(mclk), .reset(reset), .ce(ce), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .adcSample(adcSample),
    .bitClockIn(bitClockIn), .bitClockRequest(bitClockRequest), .crystalHalve(crystalHalve),
    .adcSampleTick(adcSampleTick), .systemClock(systemClock), .systemTick(systemTick),
    .coreBusClock(coreBusClock), .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
    .backendBitClock(backendBitClock), .spdifClock(spdifClock), .spdifEnable(spdifEnable),
    .debugMonitorClock(debugMonitorClock), .externalDacClock(externalDacClock),
    .dumpSample(dumpSample), .dumpValid(dumpValid));
  dcc_backend_model i_far (.mclk(mclk), .reset(reset), .demand(demand), .extRun(extRun),
    .bitClockRequest(bitClockRequest), .bitClockIn(bitClockIn));
  // free-running 100 MHz master
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // aw and w offered together, each dropped once taken; waits are cut by the watchdog
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awDone, wDone;
    @(posedge mclk);
    awAddr <= a; wData <= d; wStrb <= 4'hf; awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
    awDone = 1'b0; wDone = 1'b0;
    while (!(awDone && wDone)) begin
      @(posedge mclk);
      if (awValid && awReady) begin awDone = 1'b1; awValid <= 1'b0; end
      if (wValid && wReady) begin wDone = 1'b1; wValid <= 1'b0; end
    end
    do @(posedge mclk); while (!bValid);
    r = bResp;
    bReady <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
    do @(posedge mclk); while (!arReady);
    arValid <= 1'b0;
    if (!rValid) do @(posedge mclk); while (!rValid);
    d = rData; r = rResp;
    rReady <= 1'b0;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = spdifClock;
      1: pick = debugMonitorClock;
      2: pick = externalDacClock;
      3: pick = bitClockOut;
      4: pick = coreBusClock;
      5: pick = systemClock;
      default: pick = backendBitClock;
    endcase
  endfunction
  // second high phase, so a period already under way on the old setting is skipped
  task automatic half_of(input int s, output int h);
    repeat (2) begin
      while (!pick(s)) @(posedge mclk);
      h = 0;
      while (pick(s)) begin @(posedge mclk); h++; end
    end
  endtask
  task automatic rises(input int s, input int c, output int n);
    logic p;
    p = pick(s); n = 0;
    repeat (c) begin @(posedge mclk); if (pick(s) && !p) n++; p = pick(s); end
  endtask
  task automatic test_regs;
    logic [7:0] a[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [31:0] e[7] = '{32'h0, 32'h10, 32'h10, 32'h1010, 32'h0, 32'h0, 32'h1};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 7; i++) begin rd(a[i], d, r); chk(d, e[i]); chk(r, dcc_pkg::RESP_OKAY); end
    rd(8'h20, d, r); chk(r, dcc_pkg::RESP_SLVERR); chk(d, 32'h0);
    wr(dcc_pkg::CLOCK_STATUS, 32'hffffffff, r); chk(r, dcc_pkg::RESP_SLVERR);
    wr(dcc_pkg::ANALOG_MULTIPLIER_CONTROL, 32'h1, r); chk(crystalHalve, 1'b1);
    wr(dcc_pkg::ANALOG_MULTIPLIER_CONTROL, 32'h0, r); chk(crystalHalve, 1'b0);
    $display("regs done");
  endtask
  // spdif row set for exact single speed by software; zero half period acts as one
  task automatic test_dividers;
    logic [7:0] a[6] = '{8'h08, 8'h08, 8'h0c, 8'h0c, 8'h04, 8'h18};
    logic [31:0] d[6] = '{32'h3, 32'h0, 32'h504, 32'h504, 32'h2, 32'h3};
    int s[6] = '{0, 0, 1, 2, 3, 4};
    int e[6] = '{3, 1, 4, 5, 2, 3};
    int h;
    logic [1:0] r;
    for (int i = 0; i < 6; i++) begin wr(a[i], d[i], r); half_of(s[i], h); chk(h, e[i]); end
    $display("dividers done");
  endtask
  task automatic test_sys_dump;
    int n[6] = '{0, 1, 2, 3, 4, 7};
    int m, h;
    logic [1:0] r;
    for (int i = 0; i < 6; i++) begin
      m = (n[i] > 4) ? 4 : n[i];
      wr(dcc_pkg::SYSTEM_CLOCK_CONFIG, n[i], r);
      half_of(5, h); chk(h, 1 << m);
      repeat (3) do @(posedge mclk); while (!dumpValid);
      h = 0;
      do begin @(posedge mclk); h++; end while (!dumpValid);
      chk(h, 2 << m); chk(dumpSample, 11'h560);
    end
    $display("system and dump done");
  endtask
  task automatic test_modes;
    int n;
    logic [1:0] r;
    wr(dcc_pkg::SYSTEM_CLOCK_CONFIG, 32'h10, r);
    rises(5, 40, n); chk(n, 0); rises(0, 40, n); chk(n, 0); rises(4, 40, n); chk(n > 0, 1'b1);
    // freeze: one edge first, so the last enabled update is already in p
    ce <= 1'b0; @(posedge mclk); rises(4, 20, n); chk(n, 0); chk(adcSampleTick, 1'b0); ce <= 1'b1;
    wr(dcc_pkg::SYSTEM_CLOCK_CONFIG, 32'h0, r);
    wr(dcc_pkg::SERIAL_AUDIO_CONFIG, 32'h2, r); chk(spdifEnable, 1'b1); chk(bitClockOe, 1'b1);
    wr(dcc_pkg::SERIAL_AUDIO_CONFIG, 32'h1, r); chk(spdifEnable, 1'b0); chk(bitClockOe, 1'b0);
    extRun <= 1'b1;
    rises(6, 40, n); chk(n > 5, 1'b1);
    extRun <= 1'b0;
    wr(dcc_pkg::SERIAL_AUDIO_CONFIG, 32'h0, r);
    // gated bit clock, set above the needed bit rate by software
    wr(dcc_pkg::BIT_CLOCK_CONFIG_A, 32'h103, r);
    demand <= 1'b0;
    repeat (10) @(posedge mclk);
    rises(3, 40, n); chk(n, 0);
    demand <= 1'b1;
    half_of(3, n); chk(n, 3);
    $display("modes done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog far beyond the thousand or so cycles the tests take
  initial begin
    #500000;
    mismatches++;
    test_done;
  end
  initial begin
    reset = 1'b1; ce = 1'b1; awValid = 1'b0; wValid = 1'b0; bReady = 1'b0; arValid = 1'b0; rReady = 1'b0;
    awAddr = 8'h00; arAddr = 8'h00; wData = 32'h0; wStrb = 4'h0; demand = 1'b0; extRun = 1'b0;
    adcSample = 6'h2b;
    mismatches = 0; n_checks = 0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    test_regs;
    test_dividers;
    test_sys_dump;
    test_modes;
    test_done;
  end
endmodule
